//--- common/rcr_pkg.sv
// Package of register map, field layout and timing constants of the reset controller registers
`default_nettype none
package rcr_pkg;
  // ==========================================
  // Register offsets, interrupt registers placed above the mode register
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0c;
  localparam logic [4:0] OFF_IRQ_CLEAR = 5'h10;
  localparam logic [4:0] OFF_IRQ_EN = 5'h14;
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_MOD = 5'h08;
  // ==========================================
  // Fields
  localparam logic [7:0] KEY_VALUE = 8'ha5;
  localparam int KEY_MSB = 31;
  localparam int KEY_LSB = 24;
  localparam int CMD_CPU_BIT = 0;
  localparam int CMD_PERIPH_BIT = 2;
  localparam int CMD_PIN_BIT = 3;
  localparam int ST_FALL_BIT = 0;
  localparam int ST_CAUSE_LSB = 8;
  localparam int ST_LEVEL_BIT = 16;
  localparam int ST_BUSY_BIT = 17;
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_IEN_BIT = 4;
  localparam int MODE_LEN_LSB = 8;
  localparam logic [31:0] MODE_MASK = 32'h0000_0f11;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  // Reset causes
  localparam logic [2:0] CAUSE_GENERAL = 3'h0;
  localparam logic [2:0] CAUSE_WAKEUP = 3'h1;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
  localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
  localparam logic [2:0] CAUSE_USER = 3'h4;
  // Interrupt status bits
  localparam int IRQ_FALL_BIT = 0;
  localparam int IRQ_SWDONE_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  // ==========================================
  // Timing, in slow-clock cycles
  localparam int SW_RESET_SLOW_CYCLES = 3;
  localparam logic [1:0] SW_RESET_COUNT = 2'(SW_RESET_SLOW_CYCLES);
  // Response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- design/rcr_pulse_timer.sv
// Slow-clock-enabled pulse timer for the external pin reset length
`timescale 1ns/1ps
`default_nettype none
module rcr_pulse_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic slow_tick,
  input wire logic [3:0] length_sel,
  output logic active
);
  logic [16:0] count_reg;
  logic [16:0] count_next;
  logic [16:0] load_value;
  logic active_next;

  // 2^(L+1) slow-clock cycles
  assign load_value = 17'(17'h1 << (5'(length_sel) + 5'h1));
  assign count_next = start ? load_value :
                      (active && slow_tick) ? 17'(count_reg - 17'h1) : count_reg;
  assign active_next = start | (active & ~(slow_tick && count_reg == 17'h1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 17'h0;
      active <= 1'b0;
    end else begin
      count_reg <= count_next;
      active <= active_next;
    end
  end
endmodule // rcr_pulse_timer
`default_nettype wire

//--- design/rcr_regs.sv
// Reset controller register block with AXI4-Lite slave and external pin handling
// Functional notes
// - Command and mode writes act only when bits 31:24 equal 0xa5.
// - Command bit 0 set with valid key resets the processor.
// - Command bit 2 set with valid key resets the peripherals.
// - Command bit 3 set with valid key drives the reset pin low.
// - Status cause field reads zero after backup power-up, one after core-only power-up.
// - Status bit 0 flags a pin falling edge since the last status read.
// - Status bits 10:8 hold the cause of the last processor reset.
// - Reading status leaves the reset cause unchanged.
// - Status bit 16 shows the pin level sampled on the master clock.
// - Status bit 17 is high while a software reset runs.
// - Mode bit 0 lets a low pin level trigger a user reset.
// - Mode bit 4 with user reset off routes the fall flag to interrupt.
// - Pin reset pulse lasts 2^(L+1) slow cycles, L in mode bits 11:8.
// - Status read clears the fall flag and its interrupt.
// - Command writes are ignored while the busy flag is set.
// - A software reset lasts three slow-clock cycles then busy clears.
// - Cause records software only when the processor bit was commanded.
`timescale 1ns/1ps
`default_nettype none
module rcr_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slow_clk_in,
  input wire logic backup_power_up,
  input wire logic watchdog_reset,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic cpu_reset,
  output logic periph_reset,
  output logic irq
);
  // ==========================================
  // Synchronisers
  logic [1:0] pin_sync_reg;
  logic [1:0] slow_sync_reg;
  logic pin_level_reg;
  logic slow_prev_reg;
  logic slow_tick;
  logic pin_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_reg <= 2'h3;
      slow_sync_reg <= 2'h0;
      pin_level_reg <= 1'b1;
      slow_prev_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], pin_in};
      slow_sync_reg <= {slow_sync_reg[0], slow_clk_in};
      pin_level_reg <= pin_sync_reg[1];
      slow_prev_reg <= slow_sync_reg[1];
    end
  end
  assign slow_tick = slow_sync_reg[1] & ~slow_prev_reg;
  assign pin_fall = pin_level_reg & ~pin_sync_reg[1];

  // ==========================================
  // AXI4-Lite write channel
  logic aw_held_reg;
  logic w_held_reg;
  logic [4:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic wr_full;
  logic key_ok;
  logic wr_cmd;
  logic wr_mode;
  logic wr_clr;
  logic wr_en;
  logic wr_known;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_full = (wstrb_reg == 4'hf);
  assign key_ok = (wdata_reg[rcr_pkg::KEY_MSB:rcr_pkg::KEY_LSB] == rcr_pkg::KEY_VALUE);
  assign wr_known = (awaddr_reg == rcr_pkg::OFF_CMD) || (awaddr_reg == rcr_pkg::OFF_STAT) ||
                    (awaddr_reg == rcr_pkg::OFF_MOD) || (awaddr_reg == rcr_pkg::OFF_IRQ_STAT) ||
                    (awaddr_reg == rcr_pkg::OFF_IRQ_CLEAR) || (awaddr_reg == rcr_pkg::OFF_IRQ_EN);
  assign wr_cmd = wr_fire && wr_full && key_ok && awaddr_reg == rcr_pkg::OFF_CMD;
  assign wr_mode = wr_fire && wr_full && key_ok && awaddr_reg == rcr_pkg::OFF_MOD;
  assign wr_clr = wr_fire && wr_full && awaddr_reg == rcr_pkg::OFF_IRQ_CLEAR;
  assign wr_en = wr_fire && wr_full && awaddr_reg == rcr_pkg::OFF_IRQ_EN;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 5'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rcr_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Mode register
  logic [31:0] mode_reg;
  logic pin_reset_enable;
  logic pin_fall_irq_enable;
  logic [3:0] pin_pulse_length;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= rcr_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= wdata_reg & rcr_pkg::MODE_MASK;
    end
  end
  assign pin_reset_enable = mode_reg[rcr_pkg::MODE_EN_BIT];
  assign pin_fall_irq_enable = mode_reg[rcr_pkg::MODE_IEN_BIT];
  assign pin_pulse_length = mode_reg[rcr_pkg::MODE_LEN_LSB +: 4];

  // ==========================================
  // Software reset sequencing
  logic busy_reg;
  logic [1:0] sw_count_reg;
  logic cmd_cpu_reg;
  logic cmd_periph_reg;
  logic cmd_go;
  logic sw_done;
  logic pin_start;
  logic pin_active;

  assign cmd_go = wr_cmd && !busy_reg &&
                  (wdata_reg[rcr_pkg::CMD_CPU_BIT] || wdata_reg[rcr_pkg::CMD_PERIPH_BIT] ||
                   wdata_reg[rcr_pkg::CMD_PIN_BIT]);
  assign sw_done = busy_reg && slow_tick && sw_count_reg == 2'h1;
  assign pin_start = cmd_go && wdata_reg[rcr_pkg::CMD_PIN_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      sw_count_reg <= 2'h0;
      cmd_cpu_reg <= 1'b0;
      cmd_periph_reg <= 1'b0;
    end else if (cmd_go) begin
      busy_reg <= 1'b1;
      sw_count_reg <= rcr_pkg::SW_RESET_COUNT;
      cmd_cpu_reg <= wdata_reg[rcr_pkg::CMD_CPU_BIT];
      cmd_periph_reg <= wdata_reg[rcr_pkg::CMD_PERIPH_BIT];
    end else if (sw_done) begin
      busy_reg <= 1'b0;
      sw_count_reg <= 2'h0;
      cmd_cpu_reg <= 1'b0;
      cmd_periph_reg <= 1'b0;
    end else if (busy_reg && slow_tick) begin
      sw_count_reg <= 2'(sw_count_reg - 2'h1);
    end
  end

  rcr_pulse_timer u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(pin_start),
    .slow_tick(slow_tick),
    .length_sel(pin_pulse_length),
    .active(pin_active)
  );

  // ==========================================
  // User reset from the pin, ignored while this block drives it or a software reset runs
  logic user_reset;
  assign user_reset = pin_reset_enable && !pin_level_reg && !pin_active && !busy_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_reset <= 1'b0;
      periph_reset <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      cpu_reset <= (cmd_go && wdata_reg[rcr_pkg::CMD_CPU_BIT]) ||
                   (cmd_cpu_reg && !sw_done) || user_reset;
      periph_reset <= (cmd_go && wdata_reg[rcr_pkg::CMD_PERIPH_BIT]) ||
                      (cmd_periph_reg && !sw_done) || user_reset;
      pin_out <= 1'b0;
      pin_oe <= pin_start || pin_active;
    end
  end

  // ==========================================
  // Reset cause, caught after reset release and on each later watchdog, processor software or user reset
  logic [2:0] cause_reg;
  logic cause_init_reg;
  logic user_seen_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_reg <= rcr_pkg::CAUSE_WAKEUP;
      cause_init_reg <= 1'b0;
      user_seen_reg <= 1'b0;
    end else begin
      cause_init_reg <= 1'b1;
      if (!cause_init_reg) begin
        cause_reg <= backup_power_up ? rcr_pkg::CAUSE_GENERAL : rcr_pkg::CAUSE_WAKEUP;
      end else if (watchdog_reset) begin
        cause_reg <= rcr_pkg::CAUSE_WATCHDOG;
      end else if (sw_done && cmd_cpu_reg) begin
        cause_reg <= rcr_pkg::CAUSE_SOFTWARE;
      end else if (user_seen_reg && !user_reset) begin
        cause_reg <= rcr_pkg::CAUSE_USER;
      end
      user_seen_reg <= user_reset;
    end
  end

  // ==========================================
  // Status, fall flag and interrupts
  logic fall_flag_reg;
  logic [rcr_pkg::IRQ_WIDTH-1:0] irq_stat_reg;
  logic [rcr_pkg::IRQ_WIDTH-1:0] irq_en_reg;
  logic [rcr_pkg::IRQ_WIDTH-1:0] irq_set;
  logic rd_fire;
  logic rd_status;
  logic fall_irq;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_status = rd_fire && s_axi_araddr == rcr_pkg::OFF_STAT;
  assign fall_irq = fall_flag_reg && pin_fall_irq_enable && !pin_reset_enable;
  assign irq_set = {sw_done, pin_fall};
  assign status_word = {14'h0, busy_reg, pin_level_reg, 5'h0, cause_reg, 7'h0,
                        fall_flag_reg};
  assign rd_word = (s_axi_araddr == rcr_pkg::OFF_STAT) ? status_word :
                   (s_axi_araddr == rcr_pkg::OFF_MOD) ? mode_reg :
                   (s_axi_araddr == rcr_pkg::OFF_IRQ_STAT) ? 32'(irq_stat_reg) :
                   (s_axi_araddr == rcr_pkg::OFF_IRQ_EN) ? 32'(irq_en_reg) : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fall_flag_reg <= 1'b0;
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
      irq <= 1'b0;
    end else begin
      fall_flag_reg <= pin_fall | (fall_flag_reg & ~rd_status);
      irq_stat_reg <= irq_set | (irq_stat_reg & ~(wr_clr ? wdata_reg[1:0] : 2'h0));
      if (wr_en) begin
        irq_en_reg <= wdata_reg[1:0];
      end
      irq <= fall_irq || |(irq_stat_reg & irq_en_reg & 2'h2);
    end
  end

  // ==========================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= rcr_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (s_axi_araddr == rcr_pkg::OFF_CMD || s_axi_araddr == rcr_pkg::OFF_STAT ||
                        s_axi_araddr == rcr_pkg::OFF_MOD || s_axi_araddr == rcr_pkg::OFF_IRQ_STAT ||
                        s_axi_araddr == rcr_pkg::OFF_IRQ_CLEAR || s_axi_araddr == rcr_pkg::OFF_IRQ_EN)
                       ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // rcr_regs
`default_nettype wire

//--- test/rcr_board_model.sv
// Board side of the shared reset line: pull-up plus an optional board pull-down
`timescale 1ns/1ps
`default_nettype none
module rcr_board_model (
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic board_pull,
  output logic pin_level
);
  // Line rests high through the pull-up unless a party pulls it low
  assign pin_level = ((pin_oe && !pin_out) || board_pull) ? 1'b0 : 1'b1;
endmodule // rcr_board_model
`default_nettype wire

//--- test/rcr_regs_monitor.sv
// Port checker of the reset controller register block
`timescale 1ns/1ps
`default_nettype none
module rcr_regs_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic cpu_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Pin and reset timing
  property p_pin_low;
    pin_oe |-> !pin_out;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  property p_cpu_span;
    $rose(cpu_reset) |-> cpu_reset [*8];
  endproperty
  a_cpu_span: assert property (p_cpu_span) else $error("cpu reset too short");
  property p_cpu_end;
    $rose(cpu_reset) |-> ##[1:400] !cpu_reset;
  endproperty
  a_cpu_end: assert property (p_cpu_end) else $error("cpu reset stuck");
  property p_pulse_min;
    $rose(pin_oe) |-> pin_oe [*8];
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("pin pulse too short");
  // ==========================================
  // Bus answers
  property p_rd_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read answer dropped");
  property p_wr_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_wr_stand: assert property (p_wr_stand) else $error("write answer dropped");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_resv;
    s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:18] == 14'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
endmodule // rcr_regs_monitor
bind rcr_regs rcr_regs_monitor mon_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .pin_out, .pin_oe, .cpu_reset);
`default_nettype wire

//--- test/tb_top.sv
// Testbench of the reset controller register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic slow_clk_in, backup_power_up, watchdog_reset, pull;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [1:0] r;
  logic [3:0] sdiv, wstrb;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic pin_in, pin_out, pin_oe, cpu_reset, periph_reset, irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int err_total, cmp_count, n;
  localparam logic [31:0] KEY = {rcr_pkg::KEY_VALUE, 24'h000000};
  localparam int SLOW = 8;
  rcr_regs dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(wstrb), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slow_clk_in,
    .backup_power_up, .watchdog_reset, .pin_in, .pin_out, .pin_oe, .cpu_reset,
    .periph_reset, .irq);
  rcr_board_model board_u (.pin_out, .pin_oe, .board_pull(pull), .pin_level(pin_in));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Slow clock of SLOW master cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      sdiv <= 4'h0;
      slow_clk_in <= 1'b0;
    end else begin
      sdiv <= sdiv + 4'h1;
      slow_clk_in <= sdiv[2];
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tmo(input int k);
    if (k >= 60) begin
      err_total++;
      $display("MISMATCH %0t bus wait ran out", $time);
      summarize();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    tmo(k);
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "write resp");
  endtask
  task automatic rd(input logic [4:0] a);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(k);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] msk, input logic [31:0] exp);
    rd(a);
    chk(d & msk, exp, "read data");
  endtask
  // Re-reads status until the masked field settles, bounded
  task automatic poll(input logic [31:0] msk, input logic [31:0] exp);
    for (int k = 0; k < 40; k++) begin
      rd(rcr_pkg::OFF_STAT);
      if ((d & msk) === exp) break;
    end
    chk(d & msk, exp, "status poll");
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {watchdog_reset, pull, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    wstrb = 4'hf;
    backup_power_up = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(rcr_pkg::OFF_STAT, 32'hffff_ffff, 32'h0001_0000);
    rc(rcr_pkg::OFF_MOD, 32'hffff_ffff, 32'h0);
    wr(rcr_pkg::OFF_MOD, 32'h5a00_0f11, rcr_pkg::RESP_OKAY);
    rc(rcr_pkg::OFF_MOD, 32'hffff_ffff, 32'h0);
    wr(rcr_pkg::OFF_MOD, KEY | 32'h00ff_ffff, rcr_pkg::RESP_OKAY);
    rc(rcr_pkg::OFF_MOD, 32'hffff_ffff, 32'h0000_0f11);
    wstrb <= 4'h1;
    wr(rcr_pkg::OFF_MOD, KEY, rcr_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rc(rcr_pkg::OFF_MOD, 32'hffff_ffff, 32'h0000_0f11);
    $display("test register reset and key done");
    wr(rcr_pkg::OFF_MOD, KEY | 32'h10, rcr_pkg::RESP_OKAY);
    pull <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({31'h0, cpu_reset}, 32'h0, "user reset while disabled");
    chk({31'h0, irq}, 32'h1, "fall irq");
    rc(rcr_pkg::OFF_STAT, 32'h0001_0001, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "fall irq cleared");
    rc(rcr_pkg::OFF_STAT, 32'h0001_0000, 32'h0);
    pull <= 1'b0;
    repeat (6) @(posedge aclk);
    rc(rcr_pkg::OFF_STAT, 32'h0001_0001, 32'h0001_0000);
    $display("test pin fall flag done");
    wr(rcr_pkg::OFF_MOD, KEY | 32'h100, rcr_pkg::RESP_OKAY);
    wr(rcr_pkg::OFF_CMD, KEY | 32'h8, rcr_pkg::RESP_OKAY);
    for (n = 0; n < 400 && pin_oe === 1'b1; n++) @(posedge aclk);
    chk({31'h0, n >= 3 * SLOW - 6 && n <= 4 * SLOW}, 32'h1, "pin pulse length");
    poll(32'h0002_0000, 32'h0);
    rc(rcr_pkg::OFF_STAT, 32'h700, 32'h0);
    $display("test pin pulse done");
    wr(rcr_pkg::OFF_CMD, KEY | 32'h1, rcr_pkg::RESP_OKAY);
    chk({31'h0, cpu_reset}, 32'h1, "cpu reset");
    rc(rcr_pkg::OFF_STAT, 32'h0002_0000, 32'h0002_0000);
    wr(rcr_pkg::OFF_CMD, KEY | 32'h8, rcr_pkg::RESP_OKAY);
    chk({31'h0, pin_oe}, 32'h0, "command while busy");
    poll(32'h0002_0000, 32'h0);
    chk({31'h0, cpu_reset}, 32'h0, "cpu reset released");
    rc(rcr_pkg::OFF_STAT, 32'h700, 32'h300);
    rc(rcr_pkg::OFF_STAT, 32'h700, 32'h300);
    wr(rcr_pkg::OFF_CMD, KEY | 32'h4, rcr_pkg::RESP_OKAY);
    chk({31'h0, periph_reset}, 32'h1, "periph reset");
    chk({31'h0, cpu_reset}, 32'h0, "no cpu reset");
    poll(32'h0002_0000, 32'h0);
    rc(rcr_pkg::OFF_STAT, 32'h700, 32'h300);
    wr(rcr_pkg::OFF_CMD, 32'h5a00_0001, rcr_pkg::RESP_OKAY);
    chk({31'h0, cpu_reset}, 32'h0, "bad key command");
    $display("test software reset done");
    rc(rcr_pkg::OFF_IRQ_STAT, 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(rcr_pkg::OFF_IRQ_EN, 32'h2, rcr_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "enabled irq");
    wr(rcr_pkg::OFF_IRQ_CLEAR, 32'h2, rcr_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    rc(rcr_pkg::OFF_IRQ_STAT, 32'h2, 32'h0);
    $display("test interrupt done");
    watchdog_reset <= 1'b1;
    @(posedge aclk);
    watchdog_reset <= 1'b0;
    poll(32'h700, 32'h200);
    wr(rcr_pkg::OFF_MOD, KEY | 32'h1, rcr_pkg::RESP_OKAY);
    pull <= 1'b1;
    repeat (20) @(posedge aclk);
    chk({31'h0, cpu_reset}, 32'h1, "user reset");
    pull <= 1'b0;
    poll(32'h700, 32'h400);
    $display("test reset causes done");
    wr(5'h18, 32'h0, rcr_pkg::RESP_SLVERR);
    rd(5'h18);
    chk({30'h0, r}, {30'h0, rcr_pkg::RESP_SLVERR}, "unmapped read");
    $display("test unmapped done");
    backup_power_up <= 1'b0;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(rcr_pkg::OFF_STAT, 32'h0003_0701, 32'h0001_0100);
    rc(rcr_pkg::OFF_MOD, 32'hffff_ffff, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("test mid-run reset done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
